//--- include/mpis_consts.svh
// offsets, field positions, reset values and timing counts of the init sequencer
`ifndef MPIS_CONSTS_SVH
`define MPIS_CONSTS_SVH

`define MPIS_CLK_HZ 10000000
`define MPIS_SETTLE_NS 5000
`define MPIS_SETTLE_CYC ((`MPIS_SETTLE_NS * (`MPIS_CLK_HZ / 1000000) + 999) / 1000)
`define MPIS_PTP_TIMEOUT_US 10000
`define MPIS_PTP_TIMEOUT_CYC (`MPIS_PTP_TIMEOUT_US * (`MPIS_CLK_HZ / 1000000))
`define MPIS_PTP_EXPECTED 32'h0000_0002

`define MPIS_REG_FLOW_CFG 32'h0000_040C
`define MPIS_REG_SPEED 32'h0000_0410
`define MPIS_REG_MDIO_SETUP 32'h0000_0500
`define MPIS_REG_MDIO_CTRL 32'h0000_0504
`define MPIS_REG_MDIO_WDATA 32'h0000_0508
`define MPIS_REG_MDIO_RDATA 32'h0000_050C
`define MPIS_REG_UNI_LO 32'h0000_0700
`define MPIS_REG_UNI_HI 32'h0000_0704
`define MPIS_REG_FILT_MODE 32'h0000_0708
`define MPIS_REG_FILT_VALUE 32'h0000_0710
`define MPIS_REG_FILT_MASK 32'h0000_0750
`define MPIS_REG_RTC_CTRL 32'h0000_1000
`define MPIS_REG_PTP_TX_REQ 32'h0000_1004
`define MPIS_REG_PTP_RX_COUNT 32'h0000_1008

`define MPIS_MDIO_SETUP_VAL 32'h0000_0053
`define MPIS_MDIO_READY_POS 7
`define MPIS_MDIO_INIT_POS 11
`define MPIS_MDIO_OP_POS 14
`define MPIS_MDIO_REG_POS 16
`define MPIS_MDIO_PHY_POS 24
`define MPIS_MDIO_OP_WRITE 2'b01
`define MPIS_MDIO_OP_READ 2'b10
`define MPIS_PHY_BUS_ADDRESS 5'd7

`define MPIS_PHY_CTRL_REG 5'd0
`define MPIS_PHY_STATUS_REG 5'd1
`define MPIS_PHY_PROBE_REG 5'd2
`define MPIS_PHY_ADV_REG 5'd4
`define MPIS_PHY_GIG_REG 5'd9
`define MPIS_PHY_MODE_REG 5'd20
`define MPIS_PHY_RGMII_POS 3
`define MPIS_PHY_AN_DONE_POS 5
`define MPIS_PHY_ABSENT 16'hFFFF
`define MPIS_PHY_RESET_AN 16'h9200
`define MPIS_ADV_10 16'h0061
`define MPIS_ADV_100 16'h0181
`define MPIS_ADV_NONE 16'h0001
`define MPIS_ADV_GIG 16'h0200

`define MPIS_SPEED_10 2'b00
`define MPIS_SPEED_100 2'b01
`define MPIS_SPEED_1000 2'b10
`define MPIS_SPEED_POS 30
`define MPIS_FLOW_OFF 32'h0000_0000
`define MPIS_FILT_PROMISC 32'h8000_0000
`define MPIS_FILT_STRICT 32'h0000_0000
`define MPIS_FILT_VALUE_BYTES 96'h0605_0403_025A_0605_0403_02DA
`define MPIS_FILT_MASK_BYTES 96'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF
`define MPIS_FILT_LAST_WORD 3'd5
`define MPIS_UNI_LO_VAL 32'h0403_02DA
`define MPIS_UNI_HI_VAL 32'h0000_0605
`define MPIS_RTC_START 32'h0000_0001
`define MPIS_PTP_TX_GO 32'h0000_0001
`define MPIS_AXI_OKAY 2'b00

`define MPIS_SER_CMD_BITS 49
`define MPIS_SER_RSP_BITS 34

`endif

//--- include/mpis_pkg.sv
// types of the init sequencer
package mpis_pkg;

	typedef enum logic [4:0] {
		ST_SETTLE, ST_MDIO_CFG, ST_PROBE, ST_PROBE_CHK, ST_ADV, ST_ADV_GIG,
		ST_RGMII_RD, ST_RGMII_WR, ST_PHY_RST, ST_AN_POLL, ST_AN_CHK,
		ST_MAC_SPEED, ST_FLOW, ST_FILT_LOAD, ST_FILT_MODE, ST_UNI_LO, ST_UNI_HI,
		ST_UNI_PROM, ST_RTC, ST_PTP_REQ, ST_PTP_WAIT, ST_IDLE, ST_SERIAL,
		ST_M_POLL, ST_M_WDATA, ST_M_CTRL, ST_M_WAIT, ST_M_RDATA
	} mpis_step_t;

	typedef struct packed {
		mpis_step_t step;
		mpis_step_t ret;
		logic awvalid;
		logic wvalid;
		logic bready;
		logic arvalid;
		logic rready;
		logic [3:0] wstrb;
		logic launched;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic resp_ok;
		logic m_wr;
		logic [4:0] m_reg;
		logic [15:0] m_data;
		logic [15:0] m_rdata;
		logic [19:0] cnt;
		logic [2:0] idx;
		logic [1:0] speed;
		logic upd_q;
		logic ptp_sent;
		logic phy_present;
		logic config_done;
		logic ptp_pass;
		logic ptp_fail;
		logic cmd_take;
		logic cmd_wr;
		logic rsp_load;
	} mpis_seq_t;

	typedef struct packed {
		logic rx_busy;
		logic [5:0] rx_cnt;
		logic [48:0] rx_sh;
		logic cmd_valid;
		logic tx_busy;
		logic [5:0] tx_cnt;
		logic [33:0] tx_sh;
		logic tx_out;
	} mpis_ser_t;

endpackage

//--- rtl/mpis_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module mpis_sync #(
	parameter int WIDTH = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} mpis_sync_t;

	mpis_sync_t s_q, s_d;

	always_comb begin
		s_d.meta = din;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dout = s_q.stable;
endmodule
`default_nettype wire

//--- rtl/mpis_serial.sv
// serial request receiver and reply transmitter
`timescale 1ns/100ps
`default_nettype none
`include "mpis_consts.svh"
module mpis_serial (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ser_in,
	input wire logic cmd_take,
	input wire logic rsp_load,
	input wire logic rsp_ok,
	input wire logic [31:0] rsp_data,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [15:0] cmd_addr,
	output logic [31:0] cmd_data,
	output logic rsp_busy,
	output logic ser_out
);
	mpis_pkg::mpis_ser_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (cmd_take) begin
			s_d.cmd_valid = 1'b0;
		end
		// a start bit is only heard once the previous request was taken
		if (s_q.rx_busy) begin
			s_d.rx_sh = {s_q.rx_sh[47:0], ser_in};
			s_d.rx_cnt = s_q.rx_cnt - 6'd1;
			if (s_q.rx_cnt == 6'd1) begin
				s_d.rx_busy = 1'b0;
				s_d.cmd_valid = 1'b1;
			end
		end else if (ser_in && !s_q.cmd_valid) begin
			s_d.rx_busy = 1'b1;
			s_d.rx_cnt = 6'(`MPIS_SER_CMD_BITS);
		end
		if (s_q.tx_busy) begin
			s_d.tx_out = s_q.tx_sh[33];
			s_d.tx_sh = {s_q.tx_sh[32:0], 1'b0};
			s_d.tx_cnt = s_q.tx_cnt - 6'd1;
			if (s_q.tx_cnt == 6'd1) begin
				s_d.tx_busy = 1'b0;
			end
		end else begin
			s_d.tx_out = 1'b0;
			if (rsp_load) begin
				s_d.tx_busy = 1'b1;
				s_d.tx_sh = {1'b1, rsp_ok, rsp_data};
				s_d.tx_cnt = 6'(`MPIS_SER_RSP_BITS);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cmd_valid = s_q.cmd_valid;
	assign cmd_write = s_q.rx_sh[48];
	assign cmd_addr = s_q.rx_sh[47:32];
	assign cmd_data = s_q.rx_sh[31:0];
	assign rsp_busy = s_q.tx_busy;
	assign ser_out = s_q.tx_out;
endmodule
`default_nettype wire

//--- rtl/mpis_init_sequencer.sv
// AXI4-Lite master that brings up the MAC and PHY after reset
// Functional notes
// - after settling, write MAC to enable MDIO and set divider for 100 MHz
// - then one MDIO read at PHY bus address 7 probes for a PHY
// - probe reading all ones means no PHY; skip all further MDIO
// - with a PHY, MDIO writes set speed advertisement from speed inputs
// - RGMII selected and PHY not RGMII-only: read-modify-write PHY mode register
// - last PHY write: reset PHY and restart auto-negotiation
// - after auto-negotiation completes, write MAC speed from speed inputs
// - after speed update, write MAC configuration disabling flow control
// - with frame filter, load value and mask bytes 0 up to 11
// - filter promiscuous if PHY found or 2.5 Gb/s, else non-promiscuous
// - without frame filter, program unicast address and set promiscuous mode
// - with bridging logic, start real-time clock and exchange PTP frames
// - request exactly two PTP frames and check both come back
// - then idle; speed change request recaptures speed and reruns PHY probe
// - serial requests read or write any 16-bit address; result returns serially
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "mpis_consts.svh"
module mpis_init_sequencer #(
	parameter int unsigned PTP_TIMEOUT_CYC = `MPIS_PTP_TIMEOUT_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	output logic [31:0] m_axi_awaddr,
	output logic m_axi_awvalid,
	input wire logic m_axi_awready,
	output logic [31:0] m_axi_wdata,
	output logic [3:0] m_axi_wstrb,
	output logic m_axi_wvalid,
	input wire logic m_axi_wready,
	input wire logic [1:0] m_axi_bresp,
	input wire logic m_axi_bvalid,
	output logic m_axi_bready,
	output logic [31:0] m_axi_araddr,
	output logic m_axi_arvalid,
	input wire logic m_axi_arready,
	input wire logic [31:0] m_axi_rdata,
	input wire logic [1:0] m_axi_rresp,
	input wire logic m_axi_rvalid,
	output logic m_axi_rready,
	input wire logic [1:0] mac_speed,
	input wire logic update_speed,
	input wire logic rate_2g5,
	input wire logic rgmii_sel,
	input wire logic phy_rgmii_only,
	input wire logic filter_present,
	input wire logic avb_present,
	input wire logic serial_command,
	output logic serial_response,
	output logic config_done,
	output logic phy_present,
	output logic ptp_pass,
	output logic ptp_fail
);
	mpis_pkg::mpis_seq_t s_q, s_d;
	logic [8:0] pins;
	logic [1:0] speed_in;
	logic upd_in;
	logic r2g5_in;
	logic rgmii_in;
	logic rgonly_in;
	logic filt_in;
	logic avb_in;
	logic ser_in;
	logic acc_done;
	logic cmd_valid;
	logic cmd_write;
	logic [15:0] cmd_addr;
	logic [31:0] cmd_data;
	logic rsp_busy;

	mpis_sync #(
		.WIDTH(9)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din({serial_command, avb_present, filter_present, phy_rgmii_only, rgmii_sel, rate_2g5, update_speed,
			mac_speed}),
		.dout(pins)
	);

	assign {ser_in, avb_in, filt_in, rgonly_in, rgmii_in, r2g5_in, upd_in, speed_in} = pins;

	mpis_serial u_serial (
		.aclk(aclk),
		.aresetn(aresetn),
		.ser_in(ser_in),
		.cmd_take(s_q.cmd_take),
		.rsp_load(s_q.rsp_load),
		.rsp_ok(s_q.resp_ok),
		.rsp_data(s_q.cmd_wr ? 32'h0000_0000 : s_q.rdata),
		.cmd_valid(cmd_valid),
		.cmd_write(cmd_write),
		.cmd_addr(cmd_addr),
		.cmd_data(cmd_data),
		.rsp_busy(rsp_busy),
		.ser_out(serial_response)
	);

	// response of the single transfer in flight
	assign acc_done = (s_q.bready && m_axi_bvalid) || (s_q.rready && m_axi_rvalid);

	function automatic mpis_pkg::mpis_seq_t axi_wr(mpis_pkg::mpis_seq_t s, logic [31:0] a, logic [31:0] d);
		mpis_pkg::mpis_seq_t r;
		r = s;
		r.awvalid = 1'b1;
		r.wvalid = 1'b1;
		r.bready = 1'b1;
		r.wstrb = 4'hF;
		r.addr = a;
		r.wdata = d;
		r.launched = 1'b1;
		return r;
	endfunction

	function automatic mpis_pkg::mpis_seq_t axi_rd(mpis_pkg::mpis_seq_t s, logic [31:0] a);
		mpis_pkg::mpis_seq_t r;
		r = s;
		r.arvalid = 1'b1;
		r.rready = 1'b1;
		r.addr = a;
		r.launched = 1'b1;
		return r;
	endfunction

	function automatic mpis_pkg::mpis_seq_t mdio(mpis_pkg::mpis_seq_t s, logic wr, logic [4:0] rg, logic [15:0] d,
		mpis_pkg::mpis_step_t ret);
		mpis_pkg::mpis_seq_t r;
		r = s;
		r.m_wr = wr;
		r.m_reg = rg;
		r.m_data = d;
		r.ret = ret;
		r.step = mpis_pkg::ST_M_POLL;
		return r;
	endfunction

	function automatic logic [15:0] adv_word(logic [1:0] sp);
		logic [15:0] w;
		case (sp)
			`MPIS_SPEED_10: w = `MPIS_ADV_10;
			`MPIS_SPEED_100: w = `MPIS_ADV_100;
			default: w = `MPIS_ADV_NONE;
		endcase
		return w;
	endfunction

	always_comb begin
		logic [31:0] ctrl;
		logic [95:0] fbytes;
		ctrl = (32'(`MPIS_PHY_BUS_ADDRESS) << `MPIS_MDIO_PHY_POS) | (32'(s_q.m_reg) << `MPIS_MDIO_REG_POS)
			| (32'(s_q.m_wr ? `MPIS_MDIO_OP_WRITE : `MPIS_MDIO_OP_READ) << `MPIS_MDIO_OP_POS)
			| (32'h0000_0001 << `MPIS_MDIO_INIT_POS);
		fbytes = (s_q.idx < 3'd3) ? `MPIS_FILT_VALUE_BYTES : `MPIS_FILT_MASK_BYTES;
		s_d = s_q;
		s_d.cmd_take = 1'b0;
		s_d.rsp_load = 1'b0;
		s_d.upd_q = upd_in;
		// each valid drops on its own handshake; write address and data in either order
		if (s_q.awvalid && m_axi_awready) begin
			s_d.awvalid = 1'b0;
		end
		if (s_q.wvalid && m_axi_wready) begin
			s_d.wvalid = 1'b0;
		end
		if (s_q.arvalid && m_axi_arready) begin
			s_d.arvalid = 1'b0;
		end
		if (acc_done) begin
			s_d.launched = 1'b0;
			s_d.bready = 1'b0;
			s_d.rready = 1'b0;
			if (s_q.rready) begin
				s_d.rdata = m_axi_rdata;
				s_d.resp_ok = (m_axi_rresp == `MPIS_AXI_OKAY);
			end else begin
				s_d.resp_ok = (m_axi_bresp == `MPIS_AXI_OKAY);
			end
		end
		case (s_q.step)
			mpis_pkg::ST_SETTLE: begin
				s_d.cnt = s_q.cnt + 20'd1;
				if (s_q.cnt == 20'(`MPIS_SETTLE_CYC - 1)) begin
					s_d.cnt = 20'd0;
					s_d.speed = speed_in;
					s_d.step = mpis_pkg::ST_MDIO_CFG;
				end
			end
			mpis_pkg::ST_MDIO_CFG: begin
				if (!s_q.launched) begin
					s_d = axi_wr(s_d, `MPIS_REG_MDIO_SETUP, `MPIS_MDIO_SETUP_VAL);
				end else if (acc_done) begin
					s_d.step = mpis_pkg::ST_PROBE;
				end
			end
			mpis_pkg::ST_PROBE: begin
				s_d = mdio(s_d, 1'b0, `MPIS_PHY_PROBE_REG, 16'h0000, mpis_pkg::ST_PROBE_CHK);
			end
			mpis_pkg::ST_PROBE_CHK: begin
				s_d.phy_present = (s_q.m_rdata != `MPIS_PHY_ABSENT);
				s_d.step = s_d.phy_present ? mpis_pkg::ST_ADV : mpis_pkg::ST_MAC_SPEED;
			end
			mpis_pkg::ST_ADV: begin
				s_d = mdio(s_d, 1'b1, `MPIS_PHY_ADV_REG, adv_word(s_q.speed), mpis_pkg::ST_ADV_GIG);
			end
			mpis_pkg::ST_ADV_GIG: begin
				s_d = mdio(s_d, 1'b1, `MPIS_PHY_GIG_REG,
					(s_q.speed == `MPIS_SPEED_1000) ? `MPIS_ADV_GIG : 16'h0000, mpis_pkg::ST_RGMII_RD);
			end
			mpis_pkg::ST_RGMII_RD: begin
				if (rgmii_in && !rgonly_in) begin
					s_d = mdio(s_d, 1'b0, `MPIS_PHY_MODE_REG, 16'h0000, mpis_pkg::ST_RGMII_WR);
				end else begin
					s_d.step = mpis_pkg::ST_PHY_RST;
				end
			end
			mpis_pkg::ST_RGMII_WR: begin
				s_d = mdio(s_d, 1'b1, `MPIS_PHY_MODE_REG,
					s_q.m_rdata | (16'h0001 << `MPIS_PHY_RGMII_POS), mpis_pkg::ST_PHY_RST);
			end
			mpis_pkg::ST_PHY_RST: begin
				s_d = mdio(s_d, 1'b1, `MPIS_PHY_CTRL_REG, `MPIS_PHY_RESET_AN, mpis_pkg::ST_AN_POLL);
			end
			mpis_pkg::ST_AN_POLL: begin
				s_d = mdio(s_d, 1'b0, `MPIS_PHY_STATUS_REG, 16'h0000, mpis_pkg::ST_AN_CHK);
			end
			mpis_pkg::ST_AN_CHK: begin
				s_d.step = s_q.m_rdata[`MPIS_PHY_AN_DONE_POS] ? mpis_pkg::ST_MAC_SPEED : mpis_pkg::ST_AN_POLL;
			end
			mpis_pkg::ST_MAC_SPEED: begin
				if (!s_q.launched) begin
					s_d = axi_wr(s_d, `MPIS_REG_SPEED, 32'(s_q.speed) << `MPIS_SPEED_POS);
				end else if (acc_done) begin
					s_d.step = mpis_pkg::ST_FLOW;
				end
			end
			mpis_pkg::ST_FLOW: begin
				if (!s_q.launched) begin
					s_d = axi_wr(s_d, `MPIS_REG_FLOW_CFG, `MPIS_FLOW_OFF);
				end else if (acc_done) begin
					s_d.idx = 3'd0;
					s_d.step = filt_in ? mpis_pkg::ST_FILT_LOAD : mpis_pkg::ST_UNI_LO;
				end
			end
			mpis_pkg::ST_FILT_LOAD: begin
				// words 0..2 carry value bytes, 3..5 mask bytes, low bytes first
				if (!s_q.launched) begin
					s_d = axi_wr(s_d, ((s_q.idx < 3'd3) ? `MPIS_REG_FILT_VALUE : `MPIS_REG_FILT_MASK)
						+ 32'((s_q.idx < 3'd3 ? s_q.idx : s_q.idx - 3'd3) * 4),
						fbytes[(s_q.idx < 3'd3 ? s_q.idx : s_q.idx - 3'd3) * 32 +: 32]);
				end else if (acc_done) begin
					s_d.idx = s_q.idx + 3'd1;
					if (s_q.idx == `MPIS_FILT_LAST_WORD) begin
						s_d.step = mpis_pkg::ST_FILT_MODE;
					end
				end
			end
			mpis_pkg::ST_FILT_MODE: begin
				if (!s_q.launched) begin
					s_d = axi_wr(s_d, `MPIS_REG_FILT_MODE,
						(s_q.phy_present || r2g5_in) ? `MPIS_FILT_PROMISC : `MPIS_FILT_STRICT);
				end else if (acc_done) begin
					s_d.step = mpis_pkg::ST_RTC;
				end
			end
			mpis_pkg::ST_UNI_LO: begin
				if (!s_q.launched) begin
					s_d = axi_wr(s_d, `MPIS_REG_UNI_LO, `MPIS_UNI_LO_VAL);
				end else if (acc_done) begin
					s_d.step = mpis_pkg::ST_UNI_HI;
				end
			end
			mpis_pkg::ST_UNI_HI: begin
				if (!s_q.launched) begin
					s_d = axi_wr(s_d, `MPIS_REG_UNI_HI, `MPIS_UNI_HI_VAL);
				end else if (acc_done) begin
					s_d.step = mpis_pkg::ST_UNI_PROM;
				end
			end
			mpis_pkg::ST_UNI_PROM: begin
				if (!s_q.launched) begin
					s_d = axi_wr(s_d, `MPIS_REG_FILT_MODE, `MPIS_FILT_PROMISC);
				end else if (acc_done) begin
					s_d.step = mpis_pkg::ST_RTC;
				end
			end
			mpis_pkg::ST_RTC: begin
				if (!avb_in) begin
					s_d.step = mpis_pkg::ST_IDLE;
				end else if (!s_q.launched) begin
					s_d = axi_wr(s_d, `MPIS_REG_RTC_CTRL, `MPIS_RTC_START);
				end else if (acc_done) begin
					s_d.ptp_sent = 1'b0;
					s_d.ptp_pass = 1'b0;
					s_d.ptp_fail = 1'b0;
					s_d.step = mpis_pkg::ST_PTP_REQ;
				end
			end
			mpis_pkg::ST_PTP_REQ: begin
				if (!s_q.launched) begin
					s_d = axi_wr(s_d, `MPIS_REG_PTP_TX_REQ, `MPIS_PTP_TX_GO);
				end else if (acc_done) begin
					s_d.ptp_sent = 1'b1;
					if (s_q.ptp_sent) begin
						s_d.cnt = 20'd0;
						s_d.step = mpis_pkg::ST_PTP_WAIT;
					end
				end
			end
			mpis_pkg::ST_PTP_WAIT: begin
				s_d.cnt = s_q.cnt + 20'd1;
				if (!s_q.launched) begin
					s_d = axi_rd(s_d, `MPIS_REG_PTP_RX_COUNT);
				end else if (acc_done) begin
					if (m_axi_rdata >= `MPIS_PTP_EXPECTED) begin
						s_d.ptp_pass = 1'b1;
						s_d.step = mpis_pkg::ST_IDLE;
					end else if (s_q.cnt >= 20'(PTP_TIMEOUT_CYC)) begin
						s_d.ptp_fail = 1'b1;
						s_d.step = mpis_pkg::ST_IDLE;
					end
				end
			end
			mpis_pkg::ST_IDLE: begin
				s_d.config_done = 1'b1;
				if (upd_in && !s_q.upd_q) begin
					s_d.config_done = 1'b0;
					s_d.speed = speed_in;
					s_d.step = mpis_pkg::ST_PROBE;
				end else if (cmd_valid && !rsp_busy) begin
					s_d.cmd_take = 1'b1;
					s_d.cmd_wr = cmd_write;
					s_d.step = mpis_pkg::ST_SERIAL;
					if (cmd_write) begin
						s_d = axi_wr(s_d, 32'(cmd_addr), cmd_data);
					end else begin
						s_d = axi_rd(s_d, 32'(cmd_addr));
					end
				end
			end
			mpis_pkg::ST_SERIAL: begin
				if (acc_done) begin
					s_d.rsp_load = 1'b1;
					s_d.step = mpis_pkg::ST_IDLE;
				end
			end
			mpis_pkg::ST_M_POLL: begin
				if (!s_q.launched) begin
					s_d = axi_rd(s_d, `MPIS_REG_MDIO_CTRL);
				end else if (acc_done && m_axi_rdata[`MPIS_MDIO_READY_POS]) begin
					s_d.step = s_q.m_wr ? mpis_pkg::ST_M_WDATA : mpis_pkg::ST_M_CTRL;
				end
			end
			mpis_pkg::ST_M_WDATA: begin
				if (!s_q.launched) begin
					s_d = axi_wr(s_d, `MPIS_REG_MDIO_WDATA, 32'(s_q.m_data));
				end else if (acc_done) begin
					s_d.step = mpis_pkg::ST_M_CTRL;
				end
			end
			mpis_pkg::ST_M_CTRL: begin
				if (!s_q.launched) begin
					s_d = axi_wr(s_d, `MPIS_REG_MDIO_CTRL, ctrl);
				end else if (acc_done) begin
					s_d.step = s_q.m_wr ? s_q.ret : mpis_pkg::ST_M_WAIT;
				end
			end
			mpis_pkg::ST_M_WAIT: begin
				if (!s_q.launched) begin
					s_d = axi_rd(s_d, `MPIS_REG_MDIO_CTRL);
				end else if (acc_done && m_axi_rdata[`MPIS_MDIO_READY_POS]) begin
					s_d.step = mpis_pkg::ST_M_RDATA;
				end
			end
			mpis_pkg::ST_M_RDATA: begin
				if (!s_q.launched) begin
					s_d = axi_rd(s_d, `MPIS_REG_MDIO_RDATA);
				end else if (acc_done) begin
					s_d.m_rdata = m_axi_rdata[15:0];
					s_d.step = s_q.ret;
				end
			end
			default: begin
				s_d.step = mpis_pkg::ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign m_axi_awaddr = s_q.addr;
	assign m_axi_awvalid = s_q.awvalid;
	assign m_axi_wdata = s_q.wdata;
	assign m_axi_wstrb = s_q.wstrb;
	assign m_axi_wvalid = s_q.wvalid;
	assign m_axi_bready = s_q.bready;
	assign m_axi_araddr = s_q.addr;
	assign m_axi_arvalid = s_q.arvalid;
	assign m_axi_rready = s_q.rready;
	assign config_done = s_q.config_done;
	assign phy_present = s_q.phy_present;
	assign ptp_pass = s_q.ptp_pass;
	assign ptp_fail = s_q.ptp_fail;
endmodule
`default_nettype wire

//--- verification/mpis_monitor.sv
// assertions on the sequencer's AXI4-Lite master and status ports
`timescale 1ns/100ps
`default_nettype none
`include "mpis_consts.svh"
module mpis_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] m_axi_awaddr,
	input wire logic m_axi_awvalid,
	input wire logic m_axi_awready,
	input wire logic [31:0] m_axi_wdata,
	input wire logic [3:0] m_axi_wstrb,
	input wire logic m_axi_wvalid,
	input wire logic m_axi_wready,
	input wire logic m_axi_bvalid,
	input wire logic m_axi_bready,
	input wire logic [31:0] m_axi_araddr,
	input wire logic m_axi_arvalid,
	input wire logic m_axi_arready,
	input wire logic m_axi_rvalid,
	input wire logic m_axi_rready,
	input wire logic ptp_pass,
	input wire logic ptp_fail
);
	localparam int SETTLE = `MPIS_SETTLE_CYC;
	logic [7:0] age_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			age_q <= 8'h00;
		end else if (age_q != 8'hFF) begin
			age_q <= age_q + 8'h01;
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_settle_quiet: assert property (int'(age_q) < SETTLE - 2 |-> !m_axi_awvalid && !m_axi_arvalid)
		else $error("access during settle");
	a_aw_hold: assert property (m_axi_awvalid && !m_axi_awready |=> m_axi_awvalid && $stable(m_axi_awaddr))
		else $error("awvalid dropped");
	a_w_hold: assert property (m_axi_wvalid && !m_axi_wready |=> m_axi_wvalid && $stable(m_axi_wdata))
		else $error("wvalid dropped");
	a_ar_hold: assert property (m_axi_arvalid && !m_axi_arready |=> m_axi_arvalid && $stable(m_axi_araddr))
		else $error("arvalid dropped");
	a_one_txn: assert property (m_axi_arvalid || m_axi_rready |-> !m_axi_awvalid && !m_axi_bready)
		else $error("read and write together");
	a_aw_w_pair: assert property ($rose(m_axi_awvalid) |-> $rose(m_axi_wvalid) && m_axi_wstrb == 4'hF)
		else $error("write not paired");
	a_b_wait: assert property (m_axi_bready && !m_axi_bvalid |=> m_axi_bready)
		else $error("bready dropped");
	a_r_wait: assert property (m_axi_rready && !m_axi_rvalid |=> m_axi_rready)
		else $error("rready dropped");
	a_gap_after: assert property (m_axi_bvalid && m_axi_bready |=> !m_axi_awvalid && !m_axi_arvalid)
		else $error("no idle after response");
	a_ptp_excl: assert property (!(ptp_pass && ptp_fail))
		else $error("ptp pass and fail");
	c_write: cover property (m_axi_bvalid && m_axi_bready);
	c_read: cover property (m_axi_rvalid && m_axi_rready);
	c_pass: cover property ($rose(ptp_pass));
endmodule
bind mpis_init_sequencer mpis_monitor u_mon (.*);
`default_nettype wire

//--- verification/mpis_mac_model.sv
// AXI4-Lite management slave of the MAC with a simple PHY behind MDIO
`timescale 1ns/100ps
`default_nettype none
module mpis_mac_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] m_axi_awaddr,
	input wire logic m_axi_awvalid,
	output logic m_axi_awready,
	input wire logic [31:0] m_axi_wdata,
	input wire logic m_axi_wvalid,
	output logic m_axi_wready,
	output logic [1:0] m_axi_bresp,
	output logic m_axi_bvalid,
	input wire logic m_axi_bready,
	input wire logic [31:0] m_axi_araddr,
	input wire logic m_axi_arvalid,
	output logic m_axi_arready,
	output logic [31:0] m_axi_rdata,
	output logic [1:0] m_axi_rresp,
	output logic m_axi_rvalid,
	input wire logic m_axi_rready,
	input wire logic phy_absent,
	input wire logic slow
);
	logic [31:0] mem [int];
	logic [63:0] wlog[$];
	logic [31:0] wa, wd, ra;
	logic ga, gd, gr, tick, go;
	logic [4:0] mreg;
	int ptp_n;
	assign go = !slow || tick;
	function automatic logic [31:0] rd(input logic [31:0] a);
		if (a == 32'h0000_0504) return 32'h0000_0080;
		if (a == 32'h0000_1008) return 32'(ptp_n);
		if (a != 32'h0000_050C) return mem.exists(a) ? mem[a] : 32'h0000_0000;
		if (mreg == 5'd2) return phy_absent ? 32'h0000_FFFF : 32'h0000_0141;
		return (mreg == 5'd1) ? 32'h0000_0020 : 32'h0000_0000;
	endfunction
	always @(posedge aclk) begin
		tick <= ~tick;
		m_axi_awready <= 1'b0;
		m_axi_wready <= 1'b0;
		m_axi_arready <= 1'b0;
		if (!aresetn) begin
			{ga, gd, gr, tick, m_axi_bvalid, m_axi_rvalid} <= 6'b00_0000;
			{m_axi_bresp, m_axi_rresp, m_axi_rdata} <= 36'h0_0000_0000;
			ptp_n <= 0;
		end else begin
			if (m_axi_awvalid && !ga && go) begin
				m_axi_awready <= 1'b1;
				ga <= 1'b1;
				wa <= m_axi_awaddr;
			end
			if (m_axi_wvalid && !gd && go) begin
				m_axi_wready <= 1'b1;
				gd <= 1'b1;
				wd <= m_axi_wdata;
			end
			if (ga && gd && !m_axi_bvalid && go) begin
				m_axi_bvalid <= 1'b1;
				m_axi_bresp <= (wa >= 32'h0000_2000) ? 2'b10 : 2'b00;
				wlog.push_back({wa, wd});
				mem[wa] = wd;
				if (wa == 32'h0000_0504) mreg <= wd[20:16];
				if (wa == 32'h0000_1000 || wa == 32'h0000_1004) ptp_n <= (wa == 32'h0000_1000) ? 0 : ptp_n + 1;
			end
			if (m_axi_bvalid && m_axi_bready) begin
				{m_axi_bvalid, ga, gd} <= 3'b000;
			end
			if (m_axi_arvalid && !gr && go) begin
				m_axi_arready <= 1'b1;
				gr <= 1'b1;
				ra <= m_axi_araddr;
			end
			if (gr && !m_axi_rvalid && go) begin
				m_axi_rvalid <= 1'b1;
				m_axi_rdata <= rd(ra);
				m_axi_rresp <= (ra >= 32'h0000_2000) ? 2'b10 : 2'b00;
			end
			if (m_axi_rvalid && m_axi_rready) begin
				{m_axi_rvalid, gr} <= 2'b00;
				m_axi_rdata <= ~m_axi_rdata;
			end
		end
	end
endmodule
`default_nettype wire

//--- verification/test_mac_phy_init_sequencer.sv
// bench of the init sequencer against the MAC model
`timescale 1ns/100ps
`default_nettype none
module test_mac_phy_init_sequencer;
	logic aclk, aresetn;
	logic [31:0] m_axi_awaddr, m_axi_wdata, m_axi_araddr, m_axi_rdata;
	logic [3:0] m_axi_wstrb;
	logic [1:0] m_axi_bresp, m_axi_rresp, mac_speed;
	logic m_axi_awvalid, m_axi_awready, m_axi_wvalid, m_axi_wready, m_axi_bvalid, m_axi_bready;
	logic m_axi_arvalid, m_axi_arready, m_axi_rvalid, m_axi_rready;
	logic update_speed, rate_2g5, rgmii_sel, phy_rgmii_only, filter_present, avb_present;
	logic serial_command, serial_response, config_done, phy_present, ptp_pass, ptp_fail, phy_absent, slow;
	logic [32:0] r;
	int n_fail, total_checks, i;
	logic [63:0] exp_q[$];
	localparam logic [95:0] FV = 96'h0605_0403_025A_0605_0403_02DA;
	mpis_init_sequencer #(.PTP_TIMEOUT_CYC(200)) dut (.*);
	mpis_mac_model mac (.*);
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk_b(input logic a, input logic e);
		total_checks++;
		if (a !== e) begin
			n_fail++;
			$display("[ERR] %0t flag %b not %b", $time, a, e);
		end
	endtask
	task automatic chk_w(input logic [63:0] a, input logic [63:0] e);
		total_checks++;
		if (a !== e) begin
			n_fail++;
			$display("[ERR] %0t word %h not %h", $time, a, e);
		end
	endtask
	task automatic ew(input logic [31:0] a, input logic [31:0] d);
		exp_q.push_back({a, d});
	endtask
	task automatic mdr(input logic [4:0] g);
		ew(32'h0000_0504, {8'h07, 3'b000, g, 16'h8800});
	endtask
	task automatic mdw(input logic [4:0] g, input logic [15:0] d);
		ew(32'h0000_0508, {16'h0000, d});
		ew(32'h0000_0504, {8'h07, 3'b000, g, 16'h4800});
	endtask
	task automatic ptp_exp;
		ew(32'h0000_1000, 32'h0000_0001);
		ew(32'h0000_1004, 32'h0000_0001);
		ew(32'h0000_1004, 32'h0000_0001);
	endtask
	task automatic run_chk(input string name);
		int k;
		k = 0;
		while (config_done !== 1'b1 && k < 9000) begin
			@(posedge aclk);
			k++;
		end
		chk_b(config_done, 1'b1);
		chk_w(64'(mac.wlog.size()), 64'(exp_q.size()));
		for (k = 0; k < exp_q.size() && k < mac.wlog.size(); k++) chk_w(mac.wlog[k], exp_q[k]);
		mac.wlog.delete();
		exp_q.delete();
		$display("test %s done", name);
	endtask
	task automatic ser(input logic w, input logic [15:0] a, input logic [31:0] d);
		logic [48:0] f;
		int k;
		f = {w, a, d};
		serial_command <= 1'b1;
		for (k = 48; k >= 0; k--) begin
			@(posedge aclk);
			serial_command <= f[k];
		end
		@(posedge aclk);
		serial_command <= 1'b0;
		k = 0;
		while (serial_response !== 1'b1 && k < 500) begin
			@(posedge aclk);
			k++;
		end
		for (k = 32; k >= 0; k--) begin
			@(posedge aclk);
			r[k] = serial_response;
		end
	endtask
	initial begin
		repeat (30000) @(posedge aclk);
		n_fail++;
		$display("[ERR] %0t watchdog", $time);
		finish_test();
	end
	initial begin
		aresetn = 1'b0;
		update_speed = 1'b0;
		rate_2g5 = 1'b0;
		rgmii_sel = 1'b0;
		phy_rgmii_only = 1'b0;
		serial_command = 1'b0;
		mac_speed = 2'b01;
		filter_present = 1'b1;
		avb_present = 1'b1;
		phy_absent = 1'b1;
		slow = 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		ew(32'h0000_0500, 32'h0000_0053);
		mdr(5'd2);
		ew(32'h0000_0410, 32'h4000_0000);
		ew(32'h0000_040C, 32'h0000_0000);
		for (i = 0; i < 3; i++) ew(32'(32'h0000_0710 + 4 * i), FV[32*i+:32]);
		for (i = 0; i < 3; i++) ew(32'(32'h0000_0750 + 4 * i), 32'hFFFF_FFFF);
		ew(32'h0000_0708, 32'h0000_0000);
		ptp_exp();
		run_chk("absent");
		chk_b(phy_present, 1'b0);
		chk_b(ptp_pass, 1'b1);
		chk_b(ptp_fail, 1'b0);
		phy_absent <= 1'b0;
		slow <= 1'b1;
		mac_speed <= 2'b10;
		rgmii_sel <= 1'b1;
		filter_present <= 1'b0;
		update_speed <= 1'b1;
		repeat (4) @(posedge aclk);
		update_speed <= 1'b0;
		repeat (4) @(posedge aclk);
		mdr(5'd2);
		mdw(5'd4, 16'h0001);
		mdw(5'd9, 16'h0200);
		mdr(5'd20);
		mdw(5'd20, 16'h0008);
		mdw(5'd0, 16'h9200);
		mdr(5'd1);
		ew(32'h0000_0410, 32'h8000_0000);
		ew(32'h0000_040C, 32'h0000_0000);
		ew(32'h0000_0700, 32'h0403_02DA);
		ew(32'h0000_0704, 32'h0000_0605);
		ew(32'h0000_0708, 32'h8000_0000);
		ptp_exp();
		run_chk("present");
		chk_b(phy_present, 1'b1);
		ser(1'b1, 16'h0740, 32'hA5A5_0F0F);
		chk_b(r[32], 1'b1);
		ser(1'b0, 16'h0740, 32'h0000_0000);
		chk_w({32'h0000_0000, r[31:0]}, 64'h0000_0000_A5A5_0F0F);
		ser(1'b0, 16'hFFF0, 32'h0000_0000);
		chk_b(r[32], 1'b0);
		$display("test serial done");
		finish_test();
	end
endmodule
`default_nettype wire
